// >>> hw/lls_acgen.sv
`timescale 1ns/1ns
module lls_acgen import lls_pkg::*; #(
   parameter int CNT_W = 8
) (
   // Clock and control
   input wire logic clk,
   input wire logic rstN,
   input wire logic ce,
   // Generator setup
   input wire logic enable,
   input wire logic acEdgeSelect,
   input wire logic [CNT_W-1:0] invCount,
   // Latch pulse edges
   input wire logic lpRise,
   input wire logic lpFall,
   // Generated polarity
   output logic polarity
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic pol;
   } lls_acgen_s;

   lls_acgen_s st;
   lls_acgen_s next_st;
   logic lineEdge;

   // ------------------------------------------------------------------
   // Line counting and toggling
   // ------------------------------------------------------------------
   assign lineEdge = acEdgeSelect ? lpFall : lpRise;

   always_comb begin
      next_st = st;
      if (!enable) begin
         next_st.cnt = '0;
         next_st.pol = 1'b0;
      end else if (lineEdge) begin
         if ({1'b0, st.cnt} + 1'b1 >= {1'b0, invCount}) begin
            next_st.cnt = '0;
            next_st.pol = ~st.pol;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign polarity = st.pol;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_rise_update: assert property (@(posedge clk) disable iff (!rstN)
      ce && enable && !acEdgeSelect && lpFall && !lpRise |=> $stable(polarity))
      else $error("polarity moved on falling edge with rising edge selected");
   chk_fall_update: assert property (@(posedge clk) disable iff (!rstN)
      ce && enable && acEdgeSelect && lpFall && invCount == 8'h01 |=> polarity != $past(polarity))
      else $error("polarity did not toggle on selected falling edge");
   chk_gen_idle: assert property (@(posedge clk) disable iff (!rstN)
      ce && !enable |=> !polarity && st.cnt == '0)
      else $error("disabled generator still active");
endmodule // lls_acgen

// >>> hw/lls_level_enc.sv
`timescale 1ns/1ns
module lls_level_enc import lls_pkg::*; #(
   parameter int N = NUM_OUTPUTS
) (
   // Selection inputs
   input wire logic commonMode,
   input wire logic polarity,
   input wire logic displayOff,
   input wire logic [N-1:0] lineBits,
   // Two-bit level per output
   output logic [2*N-1:0] levels
);
   // ------------------------------------------------------------------
   // Per-output level select
   // ------------------------------------------------------------------
   for (genvar i = 0; i < N; i++) begin : g_out
      always_comb begin
         if (displayOff) begin
            levels[2*i+:2] = LEVEL_BOTTOM;
         end else begin
            case ({polarity, lineBits[i]})
               2'h0: levels[2*i+:2] = LEVEL_LOWER_MID;
               2'h1: levels[2*i+:2] = commonMode ? LEVEL_TOP : LEVEL_BOTTOM;
               2'h2: levels[2*i+:2] = LEVEL_UPPER_MID;
               default: levels[2*i+:2] = commonMode ? LEVEL_BOTTOM : LEVEL_TOP;
            endcase
         end
      end
   end
endmodule // lls_level_enc

// >>> hw/lls_pkg.sv
package lls_pkg;
   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NUM_OUTPUTS = 160;
   localparam int DATA_WORDS = 5;
   localparam int ADDR_W = 5;
   localparam int BUS_W = 8;
   localparam int PIN_W = 14;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_DATA0 = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h18;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_SOFT_OFF = 0;
   localparam int ST_COMMON = 0;
   localparam int ST_DUAL = 1;
   localparam int ST_GEN_EN = 2;
   localparam int ST_POLARITY = 3;
   localparam int ST_DISP_OFF = 4;
   localparam int ST_COUNT_LSB = 8;

   // Pin vector positions
   localparam int PIN_SEG_SEL = 0;
   localparam int PIN_DUAL = 1;
   localparam int PIN_EDGE = 2;
   localparam int PIN_DOFF_N = 3;
   localparam int PIN_FR = 4;
   localparam int PIN_LP = 5;
   localparam int PIN_BUS_LSB = 6;

   // ------------------------------------------------------------------
   // Bus values and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] BUS_ALL_ZERO = 8'h00;
   localparam logic [7:0] BUS_ALL_ONE = 8'hff;
   localparam logic [6:0] BUS7_ALL_ZERO = 7'h00;
   localparam logic [6:0] BUS7_ALL_ONE = 7'h7f;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [PIN_W-1:0] RST_PINS = 14'h0008;

   // ------------------------------------------------------------------
   // Drive level codes
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      LEVEL_BOTTOM = 2'h0,
      LEVEL_LOWER_MID = 2'h1,
      LEVEL_UPPER_MID = 2'h2,
      LEVEL_TOP = 2'h3
   } lls_level_e;
endpackage

// >>> hw/lls_top.sv
// What this block does
// - Segment select low means common (row) driver, otherwise segment driver.
// - In common mode, bus value all zeros or all ones disables generator.
// - In dual common mode, data bit 7 feeds second register half at stage 81; here bit 7 only drives the dualShiftIn output.
// - Single common mode, bus 01 to FE: generator on, all eight bits are count.
// - Dual common mode with generator on: only bits 0 to 6 form the count.
// - Edge select low: generated polarity updates on latch pulse rising edge.
// - Edge select high: generated polarity updates on latch pulse falling edge.
// - Each of 160 outputs follows its own latch bit at one of four levels.
// - Segment levels: LL lower-mid, LH bottom, HL upper-mid, HH top.
// - Common levels: LL lower-mid, LH top, HL upper-mid, HH bottom.
// - Display-off asserted forces every output to bottom level.
// - Dual mode select low: one 160-stage register; high: two 80-stage halves; here the data latch loads as five 32-bit bus words in either mode.
// - Display-off clears line latch; data latch still loads; reload on pulse fall.
// - Generator enabled: its polarity drives out on the frame polarity pin.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ns
module lls_top import lls_pkg::*; #(
   parameter int N = NUM_OUTPUTS
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Mode and timing pins from the controller
   input wire logic segCommonSel,
   input wire logic dual_mode_select,
   input wire logic ac_edge_select,
   input wire logic display_off_n,
   input wire logic line_latch_pulse,
   input wire logic [BUS_W-1:0] dataBus,
   // Frame polarity pin (two-way)
   input wire logic frame_polarity_in,
   output logic frame_polarity_out,
   output logic frame_polarity_oe,
   // Shift and generator status
   output logic dualShiftIn,
   output logic acGenEnable,
   output logic [BUS_W-1:0] invCount,
   // Driver level codes, two bits per output
   output logic [2*N-1:0] driver_outputs
);
   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic [1:0] rstPipe;
   logic rstN;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstN = rstPipe[1];

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] pinS1;
      logic [PIN_W-1:0] pinS2;
      logic lpPrev;
      logic [N-1:0] dataLatch;
      logic [N-1:0] lineLatch;
      logic softOff;
      logic waitReq;
      logic [31:0] readData;
      logic [2*N-1:0] drive;
      logic frOut;
      logic frOe;
      logic shiftIn;
      logic genEn;
      logic [BUS_W-1:0] count;
   } lls_state_s;

   lls_state_s st;
   lls_state_s next_st;

   // ------------------------------------------------------------------
   // Decoded pin view
   // ------------------------------------------------------------------
   logic commonMode;
   logic dualMode;
   logic edgeSel;
   logic offEff;
   logic extPol;
   logic lpNow;
   logic lpRise;
   logic lpFall;
   logic [BUS_W-1:0] busNow;
   logic genEnNow;
   logic [BUS_W-1:0] countNow;
   logic genPol;
   logic polarity;
   logic [2*N-1:0] levels;
   logic req;

   assign commonMode = !st.pinS2[PIN_SEG_SEL];
   assign dualMode = st.pinS2[PIN_DUAL];
   assign edgeSel = st.pinS2[PIN_EDGE];
   assign offEff = !st.pinS2[PIN_DOFF_N] || st.softOff;
   assign extPol = st.pinS2[PIN_FR];
   assign lpNow = st.pinS2[PIN_LP];
   assign busNow = st.pinS2[PIN_BUS_LSB+:BUS_W];
   assign lpRise = lpNow && !st.lpPrev;
   assign lpFall = !lpNow && st.lpPrev;
   assign req = read || write;

   // Generator enable and count
   always_comb begin
      genEnNow = 1'b0;
      countNow = '0;
      if (commonMode) begin
         if (dualMode) begin
            genEnNow = busNow[6:0] != BUS7_ALL_ZERO && busNow[6:0] != BUS7_ALL_ONE;
            countNow = {1'b0, busNow[6:0]};
         end else begin
            genEnNow = busNow != BUS_ALL_ZERO && busNow != BUS_ALL_ONE;
            countNow = busNow;
         end
      end
   end

   assign polarity = st.genEn ? genPol : extPol;

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   lls_acgen #(
      .CNT_W(BUS_W)
   ) u_acgen (
      .clk(clk),
      .rstN(rstN),
      .ce(ce),
      .enable(st.genEn),
      .acEdgeSelect(edgeSel),
      .invCount(st.count),
      .lpRise(lpRise),
      .lpFall(lpFall),
      .polarity(genPol)
   );

   lls_level_enc #(
      .N(N)
   ) u_enc (
      .commonMode(commonMode),
      .polarity(polarity),
      .displayOff(offEff),
      .lineBits(st.lineLatch),
      .levels(levels)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.pinS1 = {dataBus, line_latch_pulse, frame_polarity_in, display_off_n,
                       ac_edge_select, dual_mode_select, segCommonSel};
      next_st.pinS2 = st.pinS1;
      next_st.lpPrev = lpNow;
      next_st.genEn = genEnNow;
      next_st.count = genEnNow ? countNow : '0;
      next_st.shiftIn = commonMode && dualMode && busNow[7];
      next_st.frOe = st.genEn;
      next_st.frOut = st.genEn && genPol;
      next_st.drive = levels;
      if (offEff) begin
         next_st.lineLatch = '0;
      end else if (lpFall) begin
         next_st.lineLatch = st.dataLatch;
      end
      // Bus: one wait cycle, then answer
      next_st.waitReq = !(req && st.waitReq);
      if (req && st.waitReq) begin
         next_st.readData = RST_WORD;
         if (read) begin
            for (int w = 0; w < DATA_WORDS; w++) begin
               if (address == OFF_DATA0 + ADDR_W'(4 * w)) begin
                  next_st.readData = st.dataLatch[32*w+:32];
               end
            end
            if (address == OFF_CTRL) begin
               next_st.readData[CTRL_SOFT_OFF] = st.softOff;
            end else if (address == OFF_STATUS) begin
               next_st.readData[ST_COMMON] = commonMode;
               next_st.readData[ST_DUAL] = dualMode;
               next_st.readData[ST_GEN_EN] = st.genEn;
               next_st.readData[ST_POLARITY] = polarity;
               next_st.readData[ST_DISP_OFF] = offEff;
               next_st.readData[ST_COUNT_LSB+:BUS_W] = st.count;
            end
         end
      end
      // Data latch keeps loading even while display is off
      if (write && !st.waitReq) begin
         for (int w = 0; w < DATA_WORDS; w++) begin
            if (address == OFF_DATA0 + ADDR_W'(4 * w)) begin
               for (int b = 0; b < 4; b++) begin
                  if (byteenable[b]) begin
                     next_st.dataLatch[32*w+8*b+:8] = writedata[8*b+:8];
                  end
               end
            end
         end
         if (address == OFF_CTRL && byteenable[0]) begin
            next_st.softOff = writedata[CTRL_SOFT_OFF];
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         st <= '0;
         st.pinS1 <= RST_PINS;
         st.pinS2 <= RST_PINS;
         st.waitReq <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign readdata = st.readData;
   assign waitrequest = st.waitReq;
   assign frame_polarity_out = st.frOut;
   assign frame_polarity_oe = st.frOe;
   assign dualShiftIn = st.shiftIn;
   assign acGenEnable = st.genEn;
   assign invCount = st.count;
   assign driver_outputs = st.drive;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_bus_answer: assert property (@(posedge clk) disable iff (!rstN)
      ce && req && waitrequest |=> !waitrequest)
      else $error("bus request not answered after one wait cycle");
   chk_gen_disable: assert property (@(posedge clk) disable iff (!rstN)
      ce && commonMode && !dualMode && (busNow == BUS_ALL_ZERO || busNow == BUS_ALL_ONE) |=> !acGenEnable)
      else $error("generator enabled by all-zero or all-one bus");
   chk_count_single: assert property (@(posedge clk) disable iff (!rstN)
      ce && commonMode && !dualMode && busNow != BUS_ALL_ZERO && busNow != BUS_ALL_ONE
      |=> acGenEnable && invCount == $past(busNow))
      else $error("single mode count not taken from whole bus");
   chk_count_dual: assert property (@(posedge clk) disable iff (!rstN)
      ce && commonMode && dualMode && genEnNow |=> acGenEnable && invCount == {1'b0, $past(busNow[6:0])})
      else $error("dual mode count not taken from low seven bits");
   chk_seg_no_gen: assert property (@(posedge clk) disable iff (!rstN)
      ce && !commonMode |=> !acGenEnable && !dualShiftIn)
      else $error("segment mode ran common-mode functions");
   chk_dual_shift: assert property (@(posedge clk) disable iff (!rstN)
      ce && commonMode && dualMode |=> dualShiftIn == $past(busNow[7]))
      else $error("dual shift input not following bus bit 7");
   chk_fr_drive: assert property (@(posedge clk) disable iff (!rstN)
      ce && st.genEn |=> frame_polarity_oe && frame_polarity_out == $past(genPol))
      else $error("generated polarity not driven on frame pin");
   chk_line_clear: assert property (@(posedge clk) disable iff (!rstN)
      ce && offEff |=> st.lineLatch == '0)
      else $error("line latch not cleared during display-off");
   chk_line_load: assert property (@(posedge clk) disable iff (!rstN)
      ce && !offEff && lpFall |=> st.lineLatch == $past(st.dataLatch))
      else $error("line latch not loaded on pulse falling edge");
   chk_off_bottom: assert property (@(posedge clk) disable iff (!rstN)
      ce && offEff |=> driver_outputs == '0)
      else $error("outputs not at bottom level while display is off");
   chk_seg_levels: assert property (@(posedge clk) disable iff (!rstN)
      ce && !commonMode && !offEff |=> driver_outputs[1:0] ==
      ($past({polarity, st.lineLatch[0]}) == 2'h0 ? LEVEL_LOWER_MID :
       $past({polarity, st.lineLatch[0]}) == 2'h1 ? LEVEL_BOTTOM :
       $past({polarity, st.lineLatch[0]}) == 2'h2 ? LEVEL_UPPER_MID : LEVEL_TOP))
      else $error("segment level table mismatch");
   chk_com_levels: assert property (@(posedge clk) disable iff (!rstN)
      ce && commonMode && !offEff |=> driver_outputs[1:0] ==
      ($past({polarity, st.lineLatch[0]}) == 2'h0 ? LEVEL_LOWER_MID :
       $past({polarity, st.lineLatch[0]}) == 2'h1 ? LEVEL_TOP :
       $past({polarity, st.lineLatch[0]}) == 2'h2 ? LEVEL_UPPER_MID : LEVEL_BOTTOM))
      else $error("common level table mismatch");

   // ------------------------------------------------------------------
   // Bus, freeze and pin checks
   // ------------------------------------------------------------------
   chk_ce_freeze: assert property (@(posedge clk) disable iff (!rstN)
      !ce
      |=> $stable(st))
      else $error("state moved with ce low");
   chk_wait_idle: assert property (@(posedge clk) disable iff (!rstN)
      ce && !req
      |=> waitrequest)
      else $error("waitrequest low with no request");
   chk_write_ctrl: assert property (@(posedge clk) disable iff (!rstN)
      ce && write && !waitrequest && address == OFF_CTRL && byteenable[0]
      |=> st.softOff == $past(writedata[CTRL_SOFT_OFF]))
      else $error("control write lost");
   chk_read_unmapped: assert property (@(posedge clk) disable iff (!rstN)
      ce && read && waitrequest && address > OFF_STATUS
      |=> readdata == RST_WORD)
      else $error("unmapped read not zero");
   chk_read_data: assert property (@(posedge clk) disable iff (!rstN)
      ce && read && waitrequest && address == OFF_DATA0 + 5'h08
      |=> readdata == $past(st.dataLatch[95:64]))
      else $error("data word read back wrong");
   chk_oe_follow: assert property (@(posedge clk) disable iff (!rstN)
      ce
      |=> frame_polarity_oe == $past(acGenEnable))
      else $error("frame enable not following generator");
   chk_fr_quiet: assert property (@(posedge clk) disable iff (!rstN)
      ce && !acGenEnable
      |=> !frame_polarity_out)
      else $error("frame pin high with generator off");
   chk_count_clear: assert property (@(posedge clk) disable iff (!rstN)
      ce && !genEnNow
      |=> invCount == '0 && !acGenEnable)
      else $error("count kept with generator off");
   chk_single_shift: assert property (@(posedge clk) disable iff (!rstN)
      ce && !dualMode
      |=> !dualShiftIn)
      else $error("shift input set in single mode");
   chk_line_hold: assert property (@(posedge clk) disable iff (!rstN)
      ce && !offEff && !lpFall
      |=> $stable(st.lineLatch))
      else $error("line latch moved without pulse fall");
   chk_far_output: assert property (@(posedge clk) disable iff (!rstN)
      ce && !offEff && !commonMode && !polarity
      |=> driver_outputs[2*N-1-:2] == ($past(st.lineLatch[N-1]) ? LEVEL_BOTTOM : LEVEL_LOWER_MID))
      else $error("last output not following its bit");
   chk_status_off: assert property (@(posedge clk) disable iff (!rstN)
      ce && read && waitrequest && address == OFF_STATUS
      |=> readdata[ST_DISP_OFF] == $past(offEff))
      else $error("status display-off bit wrong");
endmodule // lls_top

// >>> verification/lls_ctrl_model.sv
`timescale 1ns/1ns
module lls_ctrl_model import lls_pkg::*; (
   // Clock
   input wire logic clk,
   // Pins toward the driver
   output logic segCommonSel,
   output logic dualModeSel,
   output logic edgeSel,
   output logic dispOffN,
   output logic latchPulse,
   output logic [BUS_W-1:0] dataBus,
   output logic framePolarity
);
   initial begin
      segCommonSel = 1'b1;
      dualModeSel = 1'b0;
      edgeSel = 1'b0;
      dispOffN = 1'b1;
      latchPulse = 1'b0;
      dataBus = 8'h00;
      framePolarity = 1'b0;
   end

   // ----------------------------------------------------------------
   // Pin tasks
   // ----------------------------------------------------------------
   // Covers the two sync flops plus two register stages
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   task automatic setPins(input logic seg, input logic dual, input logic edgeLevel,
         input logic [BUS_W-1:0] bus, input logic pol);
      @(posedge clk);
      segCommonSel <= seg;
      dualModeSel <= dual;
      edgeSel <= edgeLevel;
      dataBus <= bus;
      framePolarity <= pol;
      settle();
   endtask

   task automatic setDispOff(input logic offN);
      @(posedge clk);
      dispOffN <= offN;
      settle();
   endtask

   // Pulse stays at each level well beyond one cycle
   task automatic setLatch(input logic level);
      @(posedge clk);
      latchPulse <= level;
      settle();
   endtask
endmodule // lls_ctrl_model

// >>> verification/test_lls_top.sv
`timescale 1ns/1ns
module test_lls_top import lls_pkg::*;;
   logic clk;
   logic arst_n;
   logic ce;
   logic [ADDR_W-1:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic segSel, dualSel, edgeSel, dispOffN, latchPulse, framePolIn;
   logic [BUS_W-1:0] dataBus;
   logic framePolOut, framePolOe, dualShiftIn, acGenEnable;
   logic [BUS_W-1:0] invCount;
   logic [2*NUM_OUTPUTS-1:0] driverOutputs;
   int failures;
   int compares;

   lls_top lls_top_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .segCommonSel(segSel), .dual_mode_select(dualSel),
      .ac_edge_select(edgeSel), .display_off_n(dispOffN), .line_latch_pulse(latchPulse),
      .dataBus(dataBus), .frame_polarity_in(framePolIn), .frame_polarity_out(framePolOut),
      .frame_polarity_oe(framePolOe), .dualShiftIn(dualShiftIn), .acGenEnable(acGenEnable),
      .invCount(invCount), .driver_outputs(driverOutputs));

   lls_ctrl_model lls_ctrl_model_inst (.clk(clk), .segCommonSel(segSel), .dualModeSel(dualSel),
      .edgeSel(edgeSel), .dispOffN(dispOffN), .latchPulse(latchPulse), .dataBus(dataBus),
      .framePolarity(framePolIn));

   always #2 clk = ~clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic conclude();
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic avAccess(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] rd);
      address <= a;
      writedata <= d;
      byteenable <= be;
      if (wr) write <= 1'b1;
      else read <= 1'b1;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic avWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] unused;
      avAccess(1'b1, a, d, be, unused);
   endtask

   function automatic lls_level_e expLevel(input logic common, input logic pol, input logic bitv);
      case ({common, pol, bitv})
         3'b000, 3'b100: return LEVEL_LOWER_MID;
         3'b010, 3'b110: return LEVEL_UPPER_MID;
         3'b001, 3'b111: return LEVEL_BOTTOM;
         default: return LEVEL_TOP;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic testRegs();
      logic [31:0] rd;
      avWrite(OFF_DATA0 + 5'h08, 32'ha5a5_5a5a, 4'hf);
      avWrite(OFF_DATA0 + 5'h08, 32'hffff_ffff, 4'h2);
      avAccess(1'b0, OFF_DATA0 + 5'h08, 32'h0, 4'hf, rd);
      check(rd, 32'ha5a5_ff5a);
      avWrite(5'h1c, 32'hffff_ffff, 4'hf);
      avAccess(1'b0, 5'h1c, 32'h0, 4'hf, rd);
      check(rd, 32'h0);
   endtask

   task automatic testLevels();
      avWrite(OFF_DATA0, 32'h0000_0002, 4'hf);
      avWrite(OFF_DATA0 + 5'h10, 32'h8000_0000, 4'hf);
      for (int m = 0; m < 2; m++) begin
         for (int p = 0; p < 2; p++) begin
            lls_ctrl_model_inst.setPins(m[0], 1'b0, 1'b0, BUS_ALL_ZERO, p[0]);
            lls_ctrl_model_inst.setLatch(1'b1);
            lls_ctrl_model_inst.setLatch(1'b0);
            check(32'(driverOutputs[1:0]), 32'(expLevel(!m[0], p[0], 1'b0)));
            check(32'(driverOutputs[3:2]), 32'(expLevel(!m[0], p[0], 1'b1)));
            check(32'(driverOutputs[319:318]), 32'(expLevel(!m[0], p[0], 1'b1)));
         end
      end
   endtask

   task automatic testDispOff();
      logic [31:0] rd;
      lls_ctrl_model_inst.setPins(1'b1, 1'b0, 1'b0, BUS_ALL_ZERO, 1'b1);
      lls_ctrl_model_inst.setDispOff(1'b0);
      check(32'(|driverOutputs), 32'h0);
      avWrite(OFF_DATA0, 32'h0000_0001, 4'hf);
      lls_ctrl_model_inst.setLatch(1'b1);
      lls_ctrl_model_inst.setLatch(1'b0);
      check(32'(|driverOutputs), 32'h0);
      lls_ctrl_model_inst.setDispOff(1'b1);
      check(32'(driverOutputs[1:0]), 32'(LEVEL_UPPER_MID));
      lls_ctrl_model_inst.setLatch(1'b1);
      lls_ctrl_model_inst.setLatch(1'b0);
      check(32'(driverOutputs[1:0]), 32'(LEVEL_TOP));
      avWrite(OFF_CTRL, 32'h1, 4'hf);
      avAccess(1'b0, OFF_STATUS, 32'h0, 4'hf, rd);
      check(32'(rd[ST_DISP_OFF]), 32'h1);
      check(32'(|driverOutputs), 32'h0);
      avWrite(OFF_CTRL, 32'h0, 4'hf);
   endtask

   task automatic genCase(input logic seg, input logic dual, input logic [7:0] bus,
         input logic en, input logic [7:0] cnt, input logic sh);
      logic [31:0] rd;
      lls_ctrl_model_inst.setPins(seg, dual, 1'b0, bus, 1'b0);
      check(32'(acGenEnable), 32'(en));
      check(32'(invCount), 32'(cnt));
      check(32'(dualShiftIn), 32'(sh));
      check(32'(framePolOe), 32'(en));
      avAccess(1'b0, OFF_STATUS, 32'h0, 4'hf, rd);
      check({16'h0, rd[15:8], 5'h0, rd[2:0]}, {16'h0, cnt, 5'h0, en, dual, !seg});
   endtask

   task automatic testEdge(input logic e);
      logic p0;
      lls_ctrl_model_inst.setPins(1'b0, 1'b0, e, 8'h01, 1'b1);
      p0 = framePolOut;
      check(32'(framePolOe), 32'h1);
      lls_ctrl_model_inst.setLatch(1'b1);
      check(32'(framePolOut), 32'(p0 ^ !e));
      lls_ctrl_model_inst.setLatch(1'b0);
      check(32'(framePolOut), 32'(!p0));
      check(32'(driverOutputs[1:0]), 32'(expLevel(1'b1, !p0, 1'b1)));
   endtask

   task automatic testFreeze();
      @(posedge clk);
      ce <= 1'b0;
      lls_ctrl_model_inst.setPins(1'b0, 1'b0, 1'b0, 8'h22, 1'b0);
      check(32'(invCount), 32'h01);
      ce <= 1'b1;
      lls_ctrl_model_inst.settle();
      check(32'(invCount), 32'h22);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = '0;
      byteenable = '0;
      failures = 0;
      compares = 0;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      check(32'(waitrequest), 32'h1);
      check(driverOutputs[31:0], 32'h0);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      testRegs();
      testLevels();
      testDispOff();
      genCase(1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
      genCase(1'b0, 1'b0, 8'hff, 1'b0, 8'h00, 1'b0);
      genCase(1'b0, 1'b0, 8'h01, 1'b1, 8'h01, 1'b0);
      genCase(1'b0, 1'b0, 8'hfe, 1'b1, 8'hfe, 1'b0);
      genCase(1'b0, 1'b0, 8'h80, 1'b1, 8'h80, 1'b0);
      genCase(1'b0, 1'b1, 8'h80, 1'b0, 8'h00, 1'b1);
      genCase(1'b0, 1'b1, 8'h7f, 1'b0, 8'h00, 1'b0);
      genCase(1'b0, 1'b1, 8'h85, 1'b1, 8'h05, 1'b1);
      genCase(1'b0, 1'b1, 8'h7e, 1'b1, 8'h7e, 1'b0);
      genCase(1'b1, 1'b1, 8'h85, 1'b0, 8'h00, 1'b0);
      testEdge(1'b0);
      testEdge(1'b1);
      testFreeze();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule // test_lls_top
